//--- inc/gate_regs_pkg.sv
// Purpose: constants shared by the gate driver register bank
// Assumes: 100 MHz clk, serial frames of 16 bits, MSB first
// Notes: register offsets are the 4-bit frame addresses
// Notes on behaviour
// - primary status bit 7 is the OR of bits 6..1, warning excluded
// - bit 6 watchdog timeout, bit 5 any gate fault, bit 4 overcurrent
// - bit 3 set on motor supply undervoltage lockout
// - bit 2 charge pump undervoltage, bit 1 overtemp shutdown, bit 0 warning
// - status registers are read only, reset to zero, writes ignored
// - per-FET bits 7..4 gate faults: bridge 2 high, low, bridge 1 high, low
// - per-FET bits 3..0 overcurrent: bridge 2 high, low, bridge 1 high, low
// - control registers 2 to 5 are read/write and read back stored value
// - lock code 110b in bits 5:3 blocks writes except to register 2
// - while unlocked, lock field values other than 110b do nothing
// - 011b unlocks and is the reset value; other codes ignored when locked
// - main control bit 2 is ORed with the input1/phase pin
// - main control bit 1 is ORed with the input2/enable pin
// - writing one to main control bit 0 clears latched fault flags
// - frame: bit 15 read, bits 14..11 address, 10..8 ignored, 7..0 data
// - output low byte is register content before a write, current on read
// - control settings return to defaults on undervoltage recovery or wake
package gate_regs_pkg;
	// register addresses
	localparam logic [3:0] ADDR_FAULT_STATUS = 4'h0;
	localparam logic [3:0] ADDR_PER_FET_STATUS = 4'h1;
	localparam logic [3:0] ADDR_MAIN_CONTROL = 4'h2;
	localparam logic [3:0] ADDR_GATE_WD_CONTROL = 4'h3;
	localparam logic [3:0] ADDR_OVERCURRENT_CONTROL = 4'h4;
	localparam logic [3:0] ADDR_CHOPPING_CONTROL = 4'h5;
	// reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] MAIN_RESET = 8'h18;
	localparam logic [7:0] GATE_WD_RESET = 8'h07;
	localparam logic [7:0] OVERCURRENT_RESET = 8'h70;
	localparam logic [7:0] CHOPPING_RESET = 8'h00;
	// main control fields
	localparam int LOCK_HI = 5;
	localparam int LOCK_LO = 3;
	localparam int IN1_BIT = 2;
	localparam int IN2_BIT = 1;
	localparam int CLEAR_BIT = 0;
	localparam logic [2:0] LOCK_CODE = 3'h6;
	localparam logic [2:0] UNLOCK_CODE = 3'h3;
	// primary status fields
	localparam int SUMMARY_BIT = 7;
	localparam int WATCHDOG_BIT = 6;
	localparam int GATE_BIT = 5;
	localparam int OVERCURRENT_BIT = 4;
	localparam int SUPPLY_UV_BIT = 3;
	localparam int PUMP_UV_BIT = 2;
	localparam int SHUTDOWN_BIT = 1;
	localparam int WARNING_BIT = 0;
	// sticky flag vector: 6..0 primary bits, 14..7 per-FET bits
	localparam int FLAG_W = 15;
	localparam int PRIMARY_W = 7;
	// serial frame layout
	localparam int FRAME_BITS = 16;
	localparam int READ_BIT = 15;
	localparam int ADDR_HI = 14;
	localparam int ADDR_LO = 11;
	localparam logic [4:0] CNT_CMD = 5'h05;
	localparam logic [4:0] CNT_DATA = 5'h08;
	localparam logic [4:0] CNT_FULL = 5'h10;
	localparam logic [4:0] CNT_OVER = 5'h11;
	// synchronised pin indices
	localparam int PIN_W = 5;
	localparam int PIN_SCLK = 0;
	localparam int PIN_CS_N = 1;
	localparam int PIN_SDI = 2;
	localparam int PIN_IN1 = 3;
	localparam int PIN_IN2 = 4;
	localparam logic [4:0] PIN_RESET = 5'h02;
endpackage

//--- design/pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for outside pins
// Assumes: inputs are asynchronous to clk
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
module pin_sync
	import gate_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [PIN_W-1:0] raw,
	output logic [PIN_W-1:0] clean
);
	typedef struct packed {
		logic [PIN_W-1:0] s1;
		logic [PIN_W-1:0] s2;
		logic [PIN_W-1:0] s3;
		logic [PIN_W-1:0] clean;
	} sync_t;
	sync_t st;
	sync_t next_st;
	// shift chain; stage one feeds only stage two
	always_comb begin
		next_st = st;
		next_st.s1 = raw;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.clean = (st.s2 & st.s3) | (st.clean & (st.s2 ^ st.s3));
	end
	// register the state
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= '{PIN_RESET, PIN_RESET, PIN_RESET, PIN_RESET};
		end else begin
			st <= next_st;
		end
	end
	assign clean = st.clean;
endmodule // pin_sync

//--- design/fault_latch.sv
// Purpose: sticky fault flags with software clear
// Assumes: set events come from logic on clk
// Notes: a set in the clearing cycle survives the clear
`timescale 1ns/1ps
module fault_latch
	import gate_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [FLAG_W-1:0] set_evt,
	input wire logic clear,
	output logic [FLAG_W-1:0] flags
);
	typedef struct packed {
		logic [FLAG_W-1:0] flags;
	} latch_t;
	latch_t st;
	latch_t next_st;
	wire [FLAG_W-1:0] next_flags;
	// per-bit sticky latch, set beats clear
	genvar i;
	generate
		for (i = 0; i < FLAG_W; i++) begin : g_flag
			assign next_flags[i] = set_evt[i] | (st.flags[i] & ~clear);
		end
	endgenerate
	// one process fills the next state copy, so the copy has a single driver
	always_comb begin
		next_st = st;
		next_st.flags = next_flags;
	end
	// register the state
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st.flags <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign flags = st.flags;
endmodule // fault_latch

//--- design/gate_driver_regs.sv
// Purpose: serially reached fault and control register bank of a bridge gate driver
// Assumes: clk 100 MHz; serial clock well below clk/8; fault events on clk
// Notes: capture on falling serial clock, drive on rising serial clock
`timescale 1ns/1ps
module gate_driver_regs
	import gate_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	// serial port pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	// bridge control pins
	input wire logic input1_phase_pin,
	input wire logic input2_enable_pin,
	// wake from sleep or supply recovery, one cycle pulse
	input wire logic settings_reset,
	// fault events from the protection logic
	input wire logic watchdog_timeout_flag,
	input wire logic supply_undervoltage_flag,
	input wire logic charge_pump_undervoltage_flag,
	input wire logic overtemp_shutdown_flag,
	input wire logic overtemp_warning_flag,
	input wire logic bridge2_high_gate_fault,
	input wire logic bridge2_low_gate_fault,
	input wire logic bridge1_high_gate_fault,
	input wire logic bridge1_low_gate_fault,
	input wire logic bridge2_high_overcurrent,
	input wire logic bridge2_low_overcurrent,
	input wire logic bridge1_high_overcurrent,
	input wire logic bridge1_low_overcurrent,
	// bridge control and configuration outputs
	output logic input1_phase_control,
	output logic input2_enable_control,
	output logic fault_active,
	output logic settings_locked,
	output logic [7:0] gate_current_and_watchdog_control,
	output logic [7:0] overcurrent_monitor_control,
	output logic [7:0] chopping_config_control
);
	typedef struct packed {
		logic sclk_q;
		logic cs_q;
		logic [FRAME_BITS-1:0] rx;
		logic [4:0] cnt;
		logic [7:0] tx;
		logic sdo;
		logic sdo_oe;
		logic [7:0] main_control;
		logic [7:0] gate_wd;
		logic [7:0] ocm;
		logic [7:0] chop;
		logic in1;
		logic in2;
		logic fault_any;
		logic locked;
	} state_t;

	localparam state_t STATE_RESET = '{
		sclk_q: 1'b0,
		cs_q: 1'b1,
		rx: 16'h0000,
		cnt: 5'h00,
		tx: 8'h00,
		sdo: 1'b0,
		sdo_oe: 1'b0,
		main_control: MAIN_RESET,
		gate_wd: GATE_WD_RESET,
		ocm: OVERCURRENT_RESET,
		chop: CHOPPING_RESET,
		in1: 1'b0,
		in2: 1'b0,
		fault_any: 1'b0,
		locked: 1'b0
	};

	state_t st;
	state_t next_st;
	logic [PIN_W-1:0] raw_pins;
	logic [PIN_W-1:0] pins;
	logic [FLAG_W-1:0] set_evt;
	logic [FLAG_W-1:0] flags;
	logic [7:0] primary_status;
	logic [7:0] per_fet_status;
	logic any_gate;
	logic any_overcurrent;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic locked;
	logic [3:0] wr_addr;
	logic [7:0] wr_data;
	logic [3:0] cmd_addr;

	// outside pins go through the synchroniser
	// the serial clock is slow enough that three clk stages cost no margin
	assign raw_pins = {input2_enable_pin, input1_phase_pin, sdi, cs_n, sclk};

	pin_sync u_sync (
		.clk(clk),
		.rstn(rstn),
		.raw(raw_pins),
		.clean(pins)
	);

	// fault event collection
	// gate and overcurrent summaries latch on their own, next to the per-FET bits
	assign any_gate = bridge2_high_gate_fault | bridge2_low_gate_fault |
		bridge1_high_gate_fault | bridge1_low_gate_fault;
	assign any_overcurrent = bridge2_high_overcurrent | bridge2_low_overcurrent |
		bridge1_high_overcurrent | bridge1_low_overcurrent;

	always_comb begin
		set_evt = '0;
		set_evt[WATCHDOG_BIT] = watchdog_timeout_flag;
		set_evt[GATE_BIT] = any_gate;
		set_evt[OVERCURRENT_BIT] = any_overcurrent;
		set_evt[SUPPLY_UV_BIT] = supply_undervoltage_flag;
		set_evt[PUMP_UV_BIT] = charge_pump_undervoltage_flag;
		set_evt[SHUTDOWN_BIT] = overtemp_shutdown_flag;
		set_evt[WARNING_BIT] = overtemp_warning_flag;
		// per-FET flags, bridge 2 before bridge 1, high before low
		set_evt[FLAG_W-1:PRIMARY_W] = {
			bridge2_high_gate_fault, bridge2_low_gate_fault,
			bridge1_high_gate_fault, bridge1_low_gate_fault,
			bridge2_high_overcurrent, bridge2_low_overcurrent,
			bridge1_high_overcurrent, bridge1_low_overcurrent
		};
	end

	// sticky flags; clear comes from the stored clear bit
	// the clear bit stands for exactly one clk, so one clear per write
	fault_latch u_flags (
		.clk(clk),
		.rstn(rstn),
		.set_evt(set_evt),
		.clear(st.main_control[CLEAR_BIT]),
		.flags(flags)
	);

	// status bytes as read by the host
	// the warning bit stays out of the summary, a warm die alone is no fault
	always_comb begin
		primary_status = {1'b0, flags[PRIMARY_W-1:0]};
		primary_status[SUMMARY_BIT] = |flags[WATCHDOG_BIT:SHUTDOWN_BIT];
		per_fet_status = flags[FLAG_W-1:PRIMARY_W];
	end

	// edge detection on the filtered serial pins
	// edge registers reset to the idle pin levels, so release makes no false edge
	assign sclk_rise = pins[PIN_SCLK] & ~st.sclk_q;
	assign sclk_fall = ~pins[PIN_SCLK] & st.sclk_q;
	assign cs_fall = ~pins[PIN_CS_N] & st.cs_q;
	assign cs_rise = pins[PIN_CS_N] & ~st.cs_q;

	// lock state is held in the stored lock field
	assign locked = (st.main_control[LOCK_HI:LOCK_LO] == LOCK_CODE);

	// write target taken from a complete frame
	assign wr_addr = st.rx[ADDR_HI:ADDR_LO];
	assign wr_data = st.rx[7:0];

	// address of the frame being received, used at the fifth capture
	// only three address bits are stored then; the last one is on the pin now
	assign cmd_addr = {st.rx[2:0], pins[PIN_SDI]};

	// register read mux; unmapped addresses read as zero
	// status reads see the sticky flags, never the raw event inputs
	function automatic logic [7:0] read_reg(input logic [3:0] addr);
		logic [7:0] val;
		val = 8'h00;
		case (addr)
			ADDR_FAULT_STATUS: begin
				val = primary_status;
			end
			ADDR_PER_FET_STATUS: begin
				val = per_fet_status;
			end
			ADDR_MAIN_CONTROL: begin
				val = st.main_control;
			end
			ADDR_GATE_WD_CONTROL: begin
				val = st.gate_wd;
			end
			ADDR_OVERCURRENT_CONTROL: begin
				val = st.ocm;
			end
			ADDR_CHOPPING_CONTROL: begin
				val = st.chop;
			end
			default: begin
				val = 8'h00;
			end
		endcase
		return val;
	endfunction

	// new lock field for a main control write
	// the field only ever holds the lock or the unlock code
	function automatic logic [2:0] next_lock(input logic [2:0] cur, input logic [2:0] req);
		logic [2:0] res;
		res = cur;
		if (cur == LOCK_CODE) begin
			if (req == UNLOCK_CODE) begin
				res = UNLOCK_CODE;
			end
		end else begin
			if (req == LOCK_CODE) begin
				res = LOCK_CODE;
			end
		end
		return res; // other codes leave the state alone
	endfunction

	// serial engine, register writes and output staging
	always_comb begin
		next_st = st;
		next_st.sclk_q = pins[PIN_SCLK];
		next_st.cs_q = pins[PIN_CS_N];

		// fault clear bit drops one cycle after it was stored
		// one clk of clear is enough, the latch acts on the next edge
		if (st.main_control[CLEAR_BIT]) begin
			next_st.main_control[CLEAR_BIT] = 1'b0;
		end

		// frame start: drive the don't care bits as zero
		// a new frame also drops any half received bits of a cut frame
		if (cs_fall) begin
			next_st.cnt = 5'h00;
			next_st.rx = 16'h0000;
			next_st.tx = 8'h00;
			next_st.sdo = 1'b0;
			next_st.sdo_oe = 1'b1;
		end

		// capture on the falling serial clock, MSB first
		// the counter saturates, so an overlong frame cannot wrap to a full count
		// the cs_fall guard keeps a bit that lands with the frame start out
		if (!pins[PIN_CS_N] && !cs_fall && sclk_fall) begin
			next_st.rx = {st.rx[FRAME_BITS-2:0], pins[PIN_SDI]};
			if (st.cnt != CNT_OVER) begin
				next_st.cnt = st.cnt + 5'h01;
			end
			// command complete: snapshot the addressed register
			if (st.cnt + 5'h01 == CNT_CMD) begin
				next_st.tx = read_reg(cmd_addr);
			end
		end

		// drive on the rising serial clock; data only in the low byte
		// each bit is launched on the fifth clk edge after the host raises the serial clock, 35 ns before the host samples it
		if (!pins[PIN_CS_N] && !cs_fall && sclk_rise) begin
			if (st.cnt >= CNT_DATA && st.cnt < CNT_FULL) begin
				next_st.sdo = st.tx[7];
				next_st.tx = {st.tx[6:0], 1'b0};
			end else begin
				next_st.sdo = 1'b0;
			end
		end

		// frame end: release the output, commit a full write frame
		// only exactly sixteen captures commit; short or long frames fall away
		if (cs_rise) begin
			next_st.sdo = 1'b0;
			next_st.sdo_oe = 1'b0;
			if (st.cnt == CNT_FULL && !st.rx[READ_BIT]) begin
				case (wr_addr)
					ADDR_MAIN_CONTROL: begin
						// main control stays writable while locked
						next_st.main_control[7:6] = wr_data[7:6];
						next_st.main_control[LOCK_HI:LOCK_LO] =
							next_lock(st.main_control[LOCK_HI:LOCK_LO],
								wr_data[LOCK_HI:LOCK_LO]);
						next_st.main_control[IN1_BIT] = wr_data[IN1_BIT];
						next_st.main_control[IN2_BIT] = wr_data[IN2_BIT];
						next_st.main_control[CLEAR_BIT] = wr_data[CLEAR_BIT];
					end
					ADDR_GATE_WD_CONTROL: begin
						if (!locked) begin
							next_st.gate_wd = wr_data;
						end
					end
					ADDR_OVERCURRENT_CONTROL: begin
						if (!locked) begin
							next_st.ocm = wr_data;
						end
					end
					ADDR_CHOPPING_CONTROL: begin
						if (!locked) begin
							next_st.chop = wr_data;
						end
					end
					default: begin
						// status and unmapped addresses ignore writes
						next_st.chop = next_st.chop;
					end
				endcase
			end
		end

		// wake or supply recovery returns every setting to default
		// it wins over a commit in the same cycle; the host rewrites after wake
		if (settings_reset) begin
			next_st.main_control = MAIN_RESET;
			next_st.gate_wd = GATE_WD_RESET;
			next_st.ocm = OVERCURRENT_RESET;
			next_st.chop = CHOPPING_RESET;
		end

		// bridge inputs: pin ORed with the software bit
		next_st.in1 = pins[PIN_IN1] | st.main_control[IN1_BIT];
		next_st.in2 = pins[PIN_IN2] | st.main_control[IN2_BIT];
		next_st.fault_any = primary_status[SUMMARY_BIT];
		// lock indication moves on the same edge as the lock field
		next_st.locked = (next_st.main_control[LOCK_HI:LOCK_LO] == LOCK_CODE);
	end

	// register the state
	// synchronous reset; the pins are filtered, so release holds no hazard
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flip-flops
	// the summary output lags its status bit by one clk
	assign sdo = st.sdo;
	assign sdo_oe = st.sdo_oe;
	assign input1_phase_control = st.in1;
	assign input2_enable_control = st.in2;
	assign fault_active = st.fault_any;
	assign settings_locked = st.locked;
	assign gate_current_and_watchdog_control = st.gate_wd;
	assign overcurrent_monitor_control = st.ocm;
	assign chopping_config_control = st.chop;
endmodule // gate_driver_regs

//--- sim/regs_chk.sv
// Purpose: port-level assertions for the gate driver register bank
// Assumes: one clk domain, rstn synchronous and active low
// Notes: bound to the design from the tb file
`timescale 1ns/1ps
module regs_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic input1_phase_pin,
	input wire logic input2_enable_pin,
	input wire logic input1_phase_control,
	input wire logic input2_enable_control,
	input wire logic settings_reset,
	input wire logic watchdog_timeout_flag,
	input wire logic fault_active,
	input wire logic settings_locked,
	input wire logic [7:0] gate_current_and_watchdog_control,
	input wire logic [7:0] overcurrent_monitor_control,
	input wire logic [7:0] chopping_config_control
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic sclk_q;
	logic [4:0] falls;
	// count raw falling serial clock edges inside a frame
	always_ff @(posedge clk) begin
		sclk_q <= sclk;
		if (cs_n)
			falls <= 5'h00;
		else if (sclk_q && !sclk)
			falls <= falls + 5'h01;
	end
	// pins held long enough to pass the synchroniser
	sequence pin1_held;
		input1_phase_pin [*8];
	endsequence
	sequence pin2_held;
		input2_enable_pin [*8];
	endsequence
	sequence frame_open;
		$fell(cs_n);
	endsequence
	oe_on_a: assert property (frame_open |-> ##[2:8] sdo_oe)
		else $error("output enable missing after frame start");
	oe_off_a: assert property ($rose(cs_n) |-> ##[2:8] !sdo_oe)
		else $error("output enable stuck after frame end");
	head_zero_a: assert property (!cs_n && falls < 5'h08 |-> !sdo)
		else $error("upper response byte not zero");
	in1_or_a: assert property (pin1_held |-> input1_phase_control)
		else $error("input1 control ignores its pin");
	in2_or_a: assert property (pin2_held |-> input2_enable_control)
		else $error("input2 control ignores its pin");
	wd_flag_a: assert property (watchdog_timeout_flag |-> ##[1:2] fault_active)
		else $error("summary fault missing after watchdog event");
	clear_frame_a: assert property ($fell(fault_active) |-> cs_n)
		else $error("faults cleared outside a frame commit");
	lock_frame_a: assert property ($changed(settings_locked) |->
		cs_n || $past(settings_reset))
		else $error("lock state changed inside a frame");
	cfg_frame_a: assert property ($changed(gate_current_and_watchdog_control) |->
		cs_n || $past(settings_reset))
		else $error("register changed inside a frame");
	defaults_a: assert property (settings_reset |=>
		gate_current_and_watchdog_control == 8'h07 && overcurrent_monitor_control == 8'h70
		&& chopping_config_control == 8'h00 && !settings_locked)
		else $error("settings not restored to defaults");
	boot_vals_a: assert property ($rose(rstn) |-> !settings_locked
		&& overcurrent_monitor_control == 8'h70)
		else $error("wrong values after reset");
endmodule // regs_chk

//--- sim/spi_host.sv
// Purpose: host controller model driving serial frames
// Assumes: frames are started by the bench through xfer
// Notes: serial clock rests low between frames
`timescale 1ns/1ps
module spi_host (
	input wire logic clk,
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	// one frame of nbits, MSB first, 160 ns serial period, response shifted in
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge clk) cs_n = 1'b0;
		repeat (7) @(negedge clk);
		for (int i = 15; i > 15 - nbits; i--) begin
			@(negedge clk) sclk = 1'b1;
			sdi = tx[i];
			repeat (8) @(negedge clk);
			sclk = 1'b0;
			rx = {rx[14:0], sdo};
			repeat (7) @(negedge clk);
		end
		repeat (8) @(negedge clk);
		cs_n = 1'b1;
		sdi = ~sdi; // released line does not keep its last level
		repeat (60) @(negedge clk);
	endtask
endmodule // spi_host

//--- sim/tb.sv
// Purpose: self-checking bench for the gate driver register bank
// Assumes: clk 100 MHz, host model makes the serial clock
// Notes: inputs change on the falling clk edge
`timescale 1ns/1ps
module tb;
	logic clk, rstn, sclk, cs_n, sdi, sdo, sdo_oe, in1_pin, in2_pin, settings_reset;
	logic in1_ctl, in2_ctl, fault_active, locked;
	logic [7:0] r3, r4, r5, pm;
	logic [12:0] ev, e;
	logic [15:0] rx;
	logic [7:0] dflt [6] = '{8'h00, 8'h00, 8'h18, 8'h07, 8'h70, 8'h00};
	int err_total, total_checks;
	gate_driver_regs uut (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.sdo(sdo), .sdo_oe(sdo_oe), .input1_phase_pin(in1_pin), .input2_enable_pin(in2_pin),
		.settings_reset(settings_reset), .watchdog_timeout_flag(ev[12]),
		.supply_undervoltage_flag(ev[11]), .charge_pump_undervoltage_flag(ev[10]),
		.overtemp_shutdown_flag(ev[9]), .overtemp_warning_flag(ev[8]),
		.bridge2_high_gate_fault(ev[7]), .bridge2_low_gate_fault(ev[6]),
		.bridge1_high_gate_fault(ev[5]), .bridge1_low_gate_fault(ev[4]),
		.bridge2_high_overcurrent(ev[3]), .bridge2_low_overcurrent(ev[2]),
		.bridge1_high_overcurrent(ev[1]), .bridge1_low_overcurrent(ev[0]),
		.input1_phase_control(in1_ctl), .input2_enable_control(in2_ctl),
		.fault_active(fault_active), .settings_locked(locked),
		.gate_current_and_watchdog_control(r3), .overcurrent_monitor_control(r4),
		.chopping_config_control(r5));
	spi_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
	// free running system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// compare and count
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// write frame, response holds the old contents
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [7:0] old);
		host.xfer({1'b0, a, 3'h0, d}, 16, rx);
		check(rx, {8'h00, old});
	endtask
	// read frame, response holds the current contents
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		host.xfer({1'b1, a, 3'h7, 8'h00}, 16, rx);
		check(rx, {8'h00, exp});
	endtask
	// expected primary status for an event vector
	function automatic logic [7:0] exp_status(input logic [12:0] v);
		logic [6:0] b;
		b = {v[12], |v[7:4], |v[3:0], v[11], v[10], v[9], v[8]};
		return {|b[6:1], b};
	endfunction
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		complete_run();
	end
	initial begin
		rstn = 1'b0;
		in1_pin = 1'b0;
		in2_pin = 1'b0;
		settings_reset = 1'b0;
		ev = 13'h0000;
		err_total = 0;
		total_checks = 0;
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		repeat (6) @(negedge clk);
		foreach (dflt[a]) rd(a[3:0], dflt[a]);
		rd(4'h9, 8'h00);
		$display("test defaults done");
		for (int a = 3; a < 6; a++) begin
			wr(a[3:0], 8'hA5 ^ a[7:0], dflt[a]);
			rd(a[3:0], 8'hA5 ^ a[7:0]);
		end
		check({r3, r4}, 16'hA6A1);
		check({8'h00, r5}, 16'h00A0);
		wr(4'h0, 8'hFF, 8'h00);
		wr(4'h1, 8'hFF, 8'h00);
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		$display("test read write done");
		for (int i = 0; i < 13; i++) begin
			e = 13'h0001 << i;
			@(negedge clk) ev = e;
			@(negedge clk) ev = 13'h0000;
			repeat (4) @(negedge clk);
			rd(4'h0, exp_status(e));
			rd(4'h1, e[7:0]);
			check({15'h0000, fault_active}, {15'h0000, ~e[8]});
			wr(4'h2, 8'h19, 8'h18);
			rd(4'h2, 8'h18);
			rd(4'h0, 8'h00);
		end
		$display("test faults done");
		wr(4'h2, 8'h30, 8'h18);
		check({15'h0000, locked}, 16'h0001);
		wr(4'h3, 8'h11, 8'hA6);
		rd(4'h3, 8'hA6);
		wr(4'h2, 8'h00, 8'h30);
		rd(4'h2, 8'h30);
		wr(4'h2, 8'h18, 8'h30);
		check({15'h0000, locked}, 16'h0000);
		wr(4'h3, 8'h11, 8'hA6);
		rd(4'h3, 8'h11);
		wr(4'h2, 8'h28, 8'h18);
		rd(4'h2, 8'h18);
		$display("test lock done");
		pm = 8'h18;
		for (int k = 0; k < 4; k++) begin
			in1_pin = k[0];
			in2_pin = k[0];
			wr(4'h2, 8'h18 | {5'h00, k[1], ~k[1], 1'b0}, pm);
			pm = 8'h18 | {5'h00, k[1], ~k[1], 1'b0};
			check({15'h0000, in1_ctl}, {15'h0000, k[1] | k[0]});
			check({15'h0000, in2_ctl}, {15'h0000, ~k[1] | k[0]});
		end
		$display("test bridge inputs done");
		host.xfer({1'b0, 4'h5, 3'h0, 8'h3C}, 15, rx);
		rd(4'h5, 8'hA0);
		@(negedge clk) settings_reset = 1'b1;
		@(negedge clk) settings_reset = 1'b0;
		@(negedge clk);
		check({r3, r4}, 16'h0770);
		check({8'h00, r5}, 16'h0000);
		rd(4'h2, 8'h18);
		$display("test short frame and defaults done");
		complete_run();
	end
endmodule // tb
bind gate_driver_regs regs_chk chk (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
	.sdo(sdo), .sdo_oe(sdo_oe), .input1_phase_pin(input1_phase_pin),
	.input2_enable_pin(input2_enable_pin), .input1_phase_control(input1_phase_control),
	.input2_enable_control(input2_enable_control), .settings_reset(settings_reset),
	.watchdog_timeout_flag(watchdog_timeout_flag), .fault_active(fault_active),
	.settings_locked(settings_locked),
	.gate_current_and_watchdog_control(gate_current_and_watchdog_control),
	.overcurrent_monitor_control(overcurrent_monitor_control),
	.chopping_config_control(chopping_config_control));
